// ===== smartcard_pkg.sv
// constants shared by the smart card count, parity and divider block
package smartcard_pkg;
    // instance bases
    localparam logic [31:0] base_first  = 32'hffff0100;
    localparam logic [31:0] base_second = 32'hffff0200;
    // register offsets from the instance base
    localparam logic [11:0] off_line_ctl  = 12'h00c;
    localparam logic [11:0] off_global    = 12'h018;
    localparam logic [11:0] off_rev_dly   = 12'h024;
    localparam logic [11:0] off_clk_div   = 12'h028;
    localparam logic [11:0] off_tx_count  = 12'h02c;
    localparam logic [11:0] off_pe_thr    = 12'h030;
    localparam logic [11:0] off_rx_thr    = 12'h034;
    localparam logic [11:0] off_par_auto  = 12'h038;
    localparam logic [11:0] off_int_stat  = 12'h044;
    localparam logic [11:0] off_int_en    = 12'h048;
    // plain storage registers, slot order matters
    localparam int          plain_slots   = 13;
    localparam int          slot_select   = 12;
    localparam logic [11:0] plain_offs [plain_slots] = '{
        12'h024, 12'h040, 12'h04c, 12'h060, 12'h064, 12'h068, 12'h06c,
        12'h070, 12'h074, 12'h078, 12'h07c, 12'h080, 12'h284};
    localparam logic [31:0] plain_masks [plain_slots] = '{
        32'h000000ff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
        32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
        32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
        32'hffffffff};
    // field positions
    localparam int div_width       = 8;
    localparam int cnt_width       = 16;
    localparam int par_auto_en_bit = 8;
    localparam int fixed_par_bit   = 5;
    localparam int dir_bit         = 0;
    localparam int sw_reset_bit    = 1;
    localparam int auto_turn_bit   = 2;
    localparam int turn_en_bit     = 13;
    localparam int tx_sent_bit     = 13;
    localparam int rx_hit_bit      = 14;
    localparam int pe_hit_bit      = 7;
    // reset values
    localparam logic [31:0] rst_plain   = 32'h00000000;
    localparam logic [15:0] rst_div     = 16'h0000;
    localparam logic [15:0] rst_count   = 16'h0000;
    localparam logic [15:0] rst_int_en  = 16'h0000;
    localparam logic [15:0] rst_status  = 16'h0000;
    localparam logic [7:0]  rst_pattern = 8'h00;
    localparam logic        rst_dir     = 1'b1;
endpackage

// ===== clk_divider.sv
// programmable clock divider, output toggles every div+1 cycles
`timescale 1ns/100ps
`default_nettype none
module clk_divider (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // divide value
    input  wire logic [7:0] div,
    // divided clock
    output logic            clk_q
);
    logic [7:0] cnt_q;  // cycles since last toggle

    // count to the divide value then toggle
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q <= 8'h00;
            clk_q <= 1'b0;
        end else if (cnt_q >= div) begin
            // >= so a smaller new value never runs the count through 255
            cnt_q <= 8'h00;
            clk_q <= ~clk_q;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    a_div_toggle: assert property (@(posedge mclk) disable iff (rst)
        (cnt_q >= div) |=> (clk_q != $past(clk_q)))
        else $error("divider did not toggle at terminal count");
    a_div_hold: assert property (@(posedge mclk) disable iff (rst)
        (cnt_q < div) |=> $stable(clk_q))
        else $error("divider toggled early");
endmodule
`default_nettype wire

// ===== smartcard_count_parity_ctl.sv
// transfer counts, parity autodetect and clock dividers of the card uart
//////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module smartcard_count_parity_ctl #(
    parameter bit second_instance = 1'b0  // selects the upper base
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // register port
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [31:0] rdata,
    // character events from the uart core
    input  wire logic        char_sent,
    input  wire logic        char_rcvd,
    input  wire logic        rx_parity_err,
    input  wire logic [7:0]  rx_data,
    // line state
    output logic             line_direction,
    output logic             parity_sense,
    output logic             tx_complete,
    // count interrupts
    output logic             rx_count_irq,
    output logic             parity_irq,
    // divided clocks
    output logic             card_clk,
    output logic             front_end_clk
);
    localparam logic [31:0] base = second_instance ?
        smartcard_pkg::base_second : smartcard_pkg::base_first;

    //////////////////////////////////////////////////////////////////////
    // address decode
    logic [11:0] off;       // offset from the instance base
    logic        in_range;  // address falls in this instance
    logic        wr;        // qualified write
    logic        rd;        // qualified read

    assign off      = addr[11:0] - base[11:0];
    assign in_range = (addr[31:12] == base[31:12]) && (addr[11:0] >= base[11:0]);
    assign wr       = wr_stb && in_range;
    assign rd       = rd_stb && in_range;

    logic wr_glb;   // global control write
    logic wr_apar;  // autodetect write
    logic wr_ien;   // interrupt enable write
    logic rd_ist;   // status read, clears flags

    assign wr_glb  = wr && (off == smartcard_pkg::off_global);
    assign wr_apar = wr && (off == smartcard_pkg::off_par_auto);
    assign wr_ien  = wr && (off == smartcard_pkg::off_int_en);
    assign rd_ist  = rd && (off == smartcard_pkg::off_int_stat);

    //////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [15:0] div_q;      // both divide values
    logic [15:0] ntx_q;      // transmit count
    logic [15:0] npe_q;      // parity error threshold
    logic [15:0] nrx_q;      // receive threshold
    logic [15:0] ie_q;       // interrupt enables
    logic        ctl_par_q;  // fixed parity select
    logic        auto_q;     // auto turnaround enable
    logic        apar_en_q;  // parity autodetect enable
    logic [7:0]  pat_q;      // expected first byte

    // software written settings
    always_ff @(posedge mclk) begin
        if (rst) begin
            div_q     <= smartcard_pkg::rst_div;
            ntx_q     <= smartcard_pkg::rst_count;
            npe_q     <= smartcard_pkg::rst_count;
            nrx_q     <= smartcard_pkg::rst_count;
            ie_q      <= smartcard_pkg::rst_int_en;
            ctl_par_q <= 1'b0;
            auto_q    <= 1'b0;
            apar_en_q <= 1'b0;
            pat_q     <= smartcard_pkg::rst_pattern;
        end else if (wr) begin
            case (off)
                smartcard_pkg::off_clk_div:  div_q <= wdata[15:0];
                smartcard_pkg::off_tx_count: ntx_q <= wdata[15:0];
                smartcard_pkg::off_pe_thr:   npe_q <= wdata[15:0];
                smartcard_pkg::off_rx_thr:   nrx_q <= wdata[15:0];
                smartcard_pkg::off_int_en:   ie_q  <= wdata[15:0];
                smartcard_pkg::off_line_ctl: ctl_par_q <= wdata[smartcard_pkg::fixed_par_bit];
                smartcard_pkg::off_global:   auto_q <= wdata[smartcard_pkg::auto_turn_bit];
                smartcard_pkg::off_par_auto: begin
                    apar_en_q <= wdata[smartcard_pkg::par_auto_en_bit];
                    pat_q     <= wdata[7:0];
                end
                default: ;  // other offsets hold elsewhere
            endcase
        end
    end

    // plain storage for registers owned by other sections
    logic [31:0] store_q [smartcard_pkg::plain_slots];

    always_ff @(posedge mclk) begin
        for (int i = 0; i < smartcard_pkg::plain_slots; i++) begin
            if (rst) begin
                store_q[i] <= smartcard_pkg::rst_plain;
            end else if (wr && off == smartcard_pkg::plain_offs[i] &&
                         (i != smartcard_pkg::slot_select || second_instance)) begin
                store_q[i] <= wdata & smartcard_pkg::plain_masks[i];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // soft reset and line direction
    logic swrst_q;  // one cycle soft reset pulse
    logic dir_q;    // one receives, zero transmits
    logic dir_d;
    logic turn;     // automatic switch to receive
    logic cnt_clr;  // counter clear

    logic [15:0] tx_cnt_q;  // characters sent so far
    logic [15:0] rx_cnt_q;  // characters received so far
    logic [15:0] pe_cnt_q;  // parity errors so far
    logic        tx_hit;
    logic        rx_ev;
    logic        rx_hit;
    logic        pe_ev;
    logic        pe_hit;

    // self clearing, so the bit always reads back zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            swrst_q <= 1'b0;
        end else begin
            swrst_q <= wr_glb && wdata[smartcard_pkg::sw_reset_bit];
        end
    end

    assign tx_hit = char_sent && !dir_q && (tx_cnt_q == ntx_q);
    // char_sent marks the end of the second stop bit
    assign turn   = tx_hit && auto_q && ie_q[smartcard_pkg::turn_en_bit];

    // software write wins over the automatic switch
    always_comb begin
        dir_d = dir_q;
        if (wr_glb) begin
            dir_d = wdata[smartcard_pkg::dir_bit];
        end else if (turn) begin
            dir_d = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            dir_q <= smartcard_pkg::rst_dir;
        end else begin
            dir_q <= dir_d;
        end
    end

    assign cnt_clr = swrst_q || (dir_d != dir_q);

    //////////////////////////////////////////////////////////////////////
    // character counters
    assign rx_ev  = char_rcvd && dir_q;
    assign rx_hit = rx_ev && (rx_cnt_q == nrx_q);
    assign pe_ev  = rx_parity_err && dir_q;
    assign pe_hit = pe_ev && (pe_cnt_q == npe_q);

    // transmit count restarts after each finished sequence
    always_ff @(posedge mclk) begin
        if (rst || cnt_clr) begin
            tx_cnt_q <= smartcard_pkg::rst_count;
        end else if (tx_hit) begin
            tx_cnt_q <= smartcard_pkg::rst_count;
        end else if (char_sent && !dir_q) begin
            tx_cnt_q <= tx_cnt_q + 16'h0001;
        end
    end

    // receive count, kept running even with the flag disabled
    always_ff @(posedge mclk) begin
        if (rst || cnt_clr) begin
            rx_cnt_q <= smartcard_pkg::rst_count;
        end else if (rx_hit) begin
            rx_cnt_q <= smartcard_pkg::rst_count;
        end else if (rx_ev) begin
            rx_cnt_q <= rx_cnt_q + 16'h0001;
        end
    end

    // parity error count
    always_ff @(posedge mclk) begin
        if (rst || cnt_clr) begin
            pe_cnt_q <= smartcard_pkg::rst_count;
        end else if (pe_hit) begin
            pe_cnt_q <= smartcard_pkg::rst_count;
        end else if (pe_ev) begin
            pe_cnt_q <= pe_cnt_q + 16'h0001;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // status flags, set wins over the read clear
    logic [15:0] st_q;
    logic [15:0] st_set;
    logic [15:0] st_clr;

    always_comb begin
        st_set = 16'h0000;
        st_clr = 16'h0000;
        st_set[smartcard_pkg::rx_hit_bit]  = rx_hit && ie_q[smartcard_pkg::rx_hit_bit];
        st_set[smartcard_pkg::pe_hit_bit]  = pe_hit;
        // the automatic turnaround wipes the sent flag, even its own last set
        st_set[smartcard_pkg::tx_sent_bit] = char_sent && !dir_q && !turn;
        if (rd_ist) begin
            st_clr = 16'hffff;
        end
        st_clr[smartcard_pkg::tx_sent_bit] = rd_ist || turn;
    end

    always_ff @(posedge mclk) begin
        if (rst || swrst_q) begin
            st_q <= smartcard_pkg::rst_status;
        end else begin
            st_q <= (st_q & ~st_clr) | st_set;
        end
    end

    // registered completion pulse and count interrupt outputs
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_complete  <= 1'b0;
            rx_count_irq <= 1'b0;
            parity_irq   <= 1'b0;
        end else begin
            tx_complete  <= tx_hit;
            rx_count_irq <= st_q[smartcard_pkg::rx_hit_bit] && ie_q[smartcard_pkg::rx_hit_bit];
            parity_irq   <= st_q[smartcard_pkg::pe_hit_bit] && ie_q[smartcard_pkg::pe_hit_bit];
        end
    end

    assign line_direction = dir_q;

    //////////////////////////////////////////////////////////////////////
    // parity convention
    logic par_q;    // parity in use
    logic first_q;  // first answer byte already judged

    // a change of the fixed bit mid detection is not tracked
    always_ff @(posedge mclk) begin
        if (rst) begin
            par_q   <= 1'b0;
            first_q <= 1'b0;
        end else if (!apar_en_q || swrst_q || wr_apar) begin
            par_q   <= ctl_par_q;
            first_q <= 1'b0;
        end else if (rx_ev && !first_q) begin
            first_q <= 1'b1;
            par_q   <= (rx_data == pat_q) ? ctl_par_q : ~ctl_par_q;
        end
    end

    assign parity_sense = par_q;

    //////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe
    logic [31:0] rd_d;

    always_comb begin
        rd_d = 32'h00000000;
        case (off)
            smartcard_pkg::off_clk_div:  rd_d[15:0] = div_q;
            smartcard_pkg::off_tx_count: rd_d[15:0] = ntx_q;
            smartcard_pkg::off_pe_thr:   rd_d[15:0] = npe_q;
            smartcard_pkg::off_rx_thr:   rd_d[15:0] = nrx_q;
            smartcard_pkg::off_int_en:   rd_d[15:0] = ie_q;
            smartcard_pkg::off_int_stat: rd_d[15:0] = st_q;
            smartcard_pkg::off_line_ctl: rd_d[smartcard_pkg::fixed_par_bit] = ctl_par_q;
            smartcard_pkg::off_global: begin
                rd_d[smartcard_pkg::dir_bit]       = dir_q;
                rd_d[smartcard_pkg::auto_turn_bit] = auto_q;
            end
            default: ;  // write only and unmapped read zero
        endcase
        for (int i = 0; i < smartcard_pkg::plain_slots; i++) begin
            if (off == smartcard_pkg::plain_offs[i]) begin
                rd_d = store_q[i];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            rdata <= rd_d;
        end else begin
            rdata <= 32'h00000000;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // clock dividers, slot 0 card, slot 1 front end
    logic [1:0] div_clk;

    for (genvar g = 0; g < 2; g++) begin : g_div
        clk_divider u_div (
            .mclk  (mclk),
            .rst   (rst),
            .div   (div_q[g*smartcard_pkg::div_width +: smartcard_pkg::div_width]),
            .clk_q (div_clk[g])
        );
    end

    assign card_clk      = div_clk[0];
    assign front_end_clk = div_clk[1];

    //////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_turn_to_rx: assert property (turn && !wr_glb |=> dir_q && tx_cnt_q == 16'h0000)
        else $error("no turnaround after last character");
    a_no_turn: assert property (tx_hit && !ie_q[13] && !wr_glb |=> !dir_q)
        else $error("turned around while disabled");
    // exact one-cycle echo, so back to back completions with count zero stay legal
    a_tx_done: assert property (tx_complete == $past(tx_hit))
        else $error("sequence completion pulse wrong");
    // the line follows the enable of the cycle in which the flag first shows, software may drop it there
    a_rx_hit_flag: assert property (rx_hit && ie_q[14] && !swrst_q |=> st_q[14] ##1 rx_count_irq == $past(ie_q[14]))
        else $error("receive threshold flag missing");
    a_rx_gated: assert property (!st_q[14] && !ie_q[14] |=> !st_q[14])
        else $error("receive flag set while disabled");
    a_pe_hit_flag: assert property (pe_hit && !swrst_q |=> st_q[7])
        else $error("parity threshold flag missing");
    a_stat_clear: assert property (rd_ist && !rx_hit && !swrst_q |=> !st_q[14] ##0 rdata[14] == $past(st_q[14]))
        else $error("status read did not clear");
    a_cnt_clear: assert property (cnt_clr |=> tx_cnt_q == 16'h0000 && rx_cnt_q == 16'h0000 && pe_cnt_q == 16'h0000)
        else $error("counters not cleared");
    a_fixed_par: assert property (!apar_en_q |=> par_q == $past(ctl_par_q))
        else $error("parity not following fixed setting");
    a_auto_invert: assert property (apar_en_q && !first_q && rx_ev && rx_data != pat_q && !swrst_q && !wr_apar
                                    |=> par_q == !$past(ctl_par_q) && first_q)
        else $error("parity not inverted on mismatch");
    a_sel_absent: assert property (rd && off == smartcard_pkg::plain_offs[smartcard_pkg::slot_select] && !second_instance
                                   |=> rdata == 32'h00000000)
        else $error("slot select seen on first instance");

    c_turnaround: cover property (turn ##1 dir_q);
    c_rx_flag: cover property (rx_hit && ie_q[14] ##1 st_q[14]);
    c_par_invert: cover property (apar_en_q && rx_ev && !first_q && rx_data != pat_q);
    c_pe_flag: cover property (pe_hit ##2 parity_irq);
endmodule
`default_nettype wire

// ===== card_model.sv
// behavioural card side: character events seen by the count block
`timescale 1ns/100ps
`default_nettype none
module card_model (
    // clock
    input  wire logic       mclk,
    // character events toward the block
    output logic            char_sent,
    output logic            char_rcvd,
    output logic            rx_parity_err,
    output logic      [7:0] rx_data
);
    // idle lines at time zero
    initial begin
        char_sent     = 1'b0;
        char_rcvd     = 1'b0;
        rx_parity_err = 1'b0;
        rx_data       = 8'h00;
    end
    // n characters leave the uart, one pulse every other cycle
    task automatic send_chars(input int n);
        repeat (n) begin
            @(posedge mclk) char_sent <= 1'b1;
            @(posedge mclk) char_sent <= 1'b0;
        end
    endtask
    // one character arrives; data is only meaningful with the pulse
    task automatic recv_char(input logic [7:0] d, input logic perr);
        @(posedge mclk);
        char_rcvd     <= 1'b1;
        rx_data       <= d;
        rx_parity_err <= perr;
        @(posedge mclk);
        char_rcvd     <= 1'b0;
        rx_parity_err <= 1'b0;
        rx_data       <= ~d; // stale data must not look valid
    endtask
endmodule
`default_nettype wire

// ===== test_smartcard_count_parity_ctl.sv
// self-checking bench for the count, parity and divider block
`timescale 1ns/100ps
`default_nettype none
module test_smartcard_count_parity_ctl;
    // clock, reset and register port
    logic        mclk;
    logic        rst;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] rdata;
    logic [31:0] rdata_b;            // read data of the second instance
    bit          use_second = 1'b0;  // which instance the bus tasks talk to
    // card events and outputs
    logic        char_sent, char_rcvd, rx_parity_err;
    logic [7:0]  rx_data;
    logic        line_direction, parity_sense, tx_complete;
    logic        rx_count_irq, parity_irq, card_clk, front_end_clk;
    int          n_errors = 0;
    int          checked  = 0;
    int          n;
    //////////////////////////////////////////////////////////////////
    smartcard_count_parity_ctl DUT (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .char_sent(char_sent),
        .char_rcvd(char_rcvd), .rx_parity_err(rx_parity_err), .rx_data(rx_data),
        .line_direction(line_direction), .parity_sense(parity_sense),
        .tx_complete(tx_complete), .rx_count_irq(rx_count_irq), .parity_irq(parity_irq),
        .card_clk(card_clk), .front_end_clk(front_end_clk));
    // second instance on the same bus, only its register window is watched
    smartcard_count_parity_ctl #(.second_instance(1'b1)) DUT_b (.mclk(mclk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata_b), .char_sent(char_sent),
        .char_rcvd(char_rcvd), .rx_parity_err(rx_parity_err), .rx_data(rx_data),
        .line_direction(), .parity_sense(), .tx_complete(), .rx_count_irq(), .parity_irq(),
        .card_clk(), .front_end_clk());
    card_model card (.mclk(mclk), .char_sent(char_sent), .char_rcvd(char_rcvd),
        .rx_parity_err(rx_parity_err), .rx_data(rx_data));
    //////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // compare and count; case inequality so unknowns fail
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [11:0] off, input logic [31:0] d);
        @(posedge mclk);
        addr   <= (use_second ? smartcard_pkg::base_second : smartcard_pkg::base_first) + {20'h00000, off};
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge mclk) wr_stb <= 1'b0;
    endtask
    // read: data stands only in the cycle after the strobe
    task automatic rd(input logic [11:0] off, input logic [31:0] exp);
        @(posedge mclk);
        addr   <= (use_second ? smartcard_pkg::base_second : smartcard_pkg::base_first) + {20'h00000, off};
        rd_stb <= 1'b1;
        @(posedge mclk) rd_stb <= 1'b0;
        #1 chk(use_second ? rdata_b : rdata, exp);
        chk(use_second ? rdata : rdata_b, 32'h0);
    endtask
    // cycles in one full half period of a divided clock
    task automatic half(input bit fe, output int cnt);
        logic v;
        cnt = 0;
        @(posedge mclk) #1 v = fe ? front_end_clk : card_clk;
        while ((fe ? front_end_clk : card_clk) === v) @(posedge mclk) #1;
        v = fe ? front_end_clk : card_clk;
        while ((fe ? front_end_clk : card_clk) === v) begin
            @(posedge mclk) #1;
            cnt++;
        end
    endtask
    // verdict, single exit point
    task automatic test_done;
        $display("checked %0d, n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // hang guard, far beyond the under two hundred cycles used
    initial begin
        #200000;
        n_errors++;
        test_done;
    end
    //////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst = 1'b1;
        addr = 32'h0;
        wdata = 32'h0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk) #1 chk(line_direction, 1);
        // reset values, write-only and unmapped reads
        for (int i = 0; i < smartcard_pkg::plain_slots; i++) rd(smartcard_pkg::plain_offs[i], 0);
        for (int o = 'h28; o <= 'h3c; o += 4) rd(o[11:0], 0);
        wr(12'h284, 32'h5a);
        rd(12'h284, 0);
        wr(12'h040, 32'hdeadbeef);
        rd(12'h040, 32'hdeadbeef);
        // second instance: own window, slot select present
        use_second = 1'b1;
        rd(12'h040, 0);
        wr(12'h284, 32'h5a);
        rd(12'h284, 32'h5a);
        use_second = 1'b0;
        wr(12'h038, 32'h1ff);
        rd(12'h038, 0);
        wr(12'h038, 32'h0);
        $display("test registers done");
        // dividers: half period is div+1 cycles
        wr(12'h028, 32'hffff0201);
        rd(12'h028, 32'h0201);
        half(0, n);
        chk(n, 2);
        half(1, n);
        chk(n, 3);
        $display("test dividers done");
        // receive threshold 2, interrupt enabled then disabled
        wr(12'h048, 32'h4080);
        wr(12'h034, 32'h2);
        repeat (2) card.recv_char(8'h11, 0);
        @(posedge mclk) #1 chk(rx_count_irq, 0);
        card.recv_char(8'h11, 0);
        @(posedge mclk) #1 chk(rx_count_irq, 1);
        rd(12'h044, 32'h4000);
        rd(12'h044, 32'h0);
        wr(12'h048, 32'h0080);
        repeat (3) card.recv_char(8'h22, 0);
        rd(12'h044, 32'h0);
        // parity error threshold zero: first error flags
        wr(12'h030, 32'h0);
        card.recv_char(8'h33, 1);
        @(posedge mclk) #1 chk(parity_irq, 1);
        rd(12'h044, 32'h0080);
        $display("test thresholds done");
        // transmit count 1 means two characters, then turnaround
        wr(12'h02c, 32'h1);
        wr(12'h048, 32'h2000);
        wr(12'h018, 32'h4);
        @(posedge mclk) #1 chk(line_direction, 0);
        card.send_chars(1);
        #1 chk(tx_complete, 0);
        card.send_chars(1);
        #1 chk({tx_complete, line_direction}, 2'b11);
        @(posedge mclk) #1 chk(tx_complete, 0);
        // turnaround enable clear: sequence ends, line keeps transmitting
        wr(12'h048, 32'h0);
        wr(12'h018, 32'h4);
        card.send_chars(2);
        #1 chk({tx_complete, line_direction}, 2'b10);
        rd(12'h044, 32'h2000);
        wr(12'h018, 32'h1);
        $display("test transmit done");
        // autodetect: disable while idle before fixed parity setup
        wr(12'h038, 32'h0);
        wr(12'h00c, 32'h20);
        wr(12'h038, 32'h13b);
        card.recv_char(8'h3b, 0);
        #1 chk(parity_sense, 1);
        wr(12'h018, 32'h3);
        card.recv_char(8'h3f, 0);
        #1 chk(parity_sense, 0);
        wr(12'h038, 32'h0);
        repeat (2) @(posedge mclk) #1;
        chk(parity_sense, 1);
        wr(12'h00c, 32'h0);
        repeat (2) @(posedge mclk) #1;
        chk(parity_sense, 0);
        $display("test parity done");
        test_done;
    end
endmodule
`default_nettype wire
